// ---- rtl/sbd_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
// Combinational security filter and slave decode
module sbd_filter (
    // Request
    input  wire sbd_pkg::sbd_req_t i_req,
    input  wire sbd_pkg::sbd_sec_t i_sec,
    // Verdict
    output logic                   o_allow,
    output logic [2:0]             o_sel
);
    import sbd_pkg::*;

    function automatic logic in_win(input logic [35:0] a, input logic [35:0] lo,
                                    input logic [35:0] hi);
        in_win = (a >= lo) && (a < hi);
    endfunction

    logic [35:0] a;
    logic        aligned;
    logic        upage_rd;
    logic        mbox;
    logic        sec_fl;
    logic        sec_ram;
    logic        user_fl;
    logic        fctl;
    logic [35:0] fl_len;
    logic [35:0] ram_len;

    // Window hits
    always_comb begin
        a       = i_req.addr;
        fl_len  = {20'h00000, i_sec.upage_w[15:0]} << SBD_LEN_SHIFT;
        ram_len = {20'h00000, i_sec.upage_w[31:16]} << SBD_LEN_SHIFT;
        upage_rd = !i_req.write && in_win(a, SBD_UPAGE_LO, SBD_UPAGE_HI);
        mbox     = in_win(a, SBD_MBOX_LO, SBD_MBOX_HI);
        sec_fl   = in_win(a, SBD_FLASH_BASE, SBD_FLASH_BASE + fl_len);
        sec_ram  = in_win(a, SBD_RAM_BASE, SBD_RAM_BASE + ram_len);
        fctl     = in_win(a, SBD_FCTL_LO, SBD_FCTL_HI);
        user_fl  = in_win(a, SBD_FLASH_BASE + i_sec.boot_size,
                          SBD_FLASH_BASE + i_sec.flash_size);
        case (i_req.size)
            SBD_SZ_BYTE: aligned = 1'b1;
            SBD_SZ_HALF: aligned = !a[0];
            SBD_SZ_WORD: aligned = (a[1:0] == 2'b00);
            default:     aligned = 1'b0;
        endcase
    end

    // Slave decode on the top nibble, offset passes through
    always_comb begin
        case (a[35:32])
            SBD_SLV_DBG:  o_sel = 3'b001;
            SBD_SLV_HSB,
            SBD_SLV_HSB2: o_sel = 3'b010;
            SBD_SLV_MSU:  o_sel = 3'b100;
            default:      o_sel = 3'b000;
        endcase
    end

    // Measures combine; the strictest one wins
    always_comb begin
        o_allow = aligned && (o_sel != 3'b000);
        if (i_sec.sec_bit && i_sec.user_code_protect) begin
            // Debug only via secure-flash software, not this path
            o_allow = o_allow && (mbox || upage_rd || fctl || user_fl);
        end else if (i_sec.sec_bit) begin
            o_allow = o_allow && (mbox || upage_rd);
        end
        if (i_sec.secure) begin
            if ((sec_fl && !upage_rd) || sec_ram)
                o_allow = 1'b0;
            if (in_win(a, SBD_UPAGE_LO, SBD_UPAGE_HI) && i_req.write)
                o_allow = 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- rtl/sbd_pkg.sv ----
package sbd_pkg;

    // Service bus geometry
    localparam int SBD_ADDR_W = 36;
    localparam int SBD_DATA_W = 32;

    // Slave codes in address bits 35:32
    localparam logic [3:0] SBD_SLV_NONE = 4'h0;
    localparam logic [3:0] SBD_SLV_DBG  = 4'h1;
    localparam logic [3:0] SBD_SLV_HSB  = 4'h4;
    localparam logic [3:0] SBD_SLV_HSB2 = 4'h5;
    localparam logic [3:0] SBD_SLV_MSU  = 4'h6;

    // Protected windows
    localparam logic [35:0] SBD_FLASH_BASE = 36'h580000000;
    localparam logic [35:0] SBD_RAM_BASE   = 36'h500000000;
    localparam logic [35:0] SBD_UPAGE_LO   = 36'h580800000;
    localparam logic [35:0] SBD_UPAGE_HI   = 36'h581000000;
    localparam logic [35:0] SBD_MBOX_LO    = 36'h100000110;
    localparam logic [35:0] SBD_MBOX_HI    = 36'h100000118;
    localparam logic [35:0] SBD_FCTL_LO    = 36'h5fffe0000;
    localparam logic [35:0] SBD_FCTL_HI    = 36'h5fffe0400;
    localparam int          SBD_LEN_SHIFT  = 10;

    // Transfer sizes
    typedef enum logic [1:0] {
        SBD_SZ_BYTE = 2'b00,
        SBD_SZ_HALF = 2'b01,
        SBD_SZ_WORD = 2'b10
    } sbd_size_t;

    // Target select one-hot positions
    localparam int SBD_TGT_DBG = 0;
    localparam int SBD_TGT_HSB = 1;
    localparam int SBD_TGT_MSU = 2;

    // APB register map
    localparam logic [11:0] SBD_REG_PCLK  = 12'h000;
    localparam logic [11:0] SBD_REG_SECCF = 12'h004;
    localparam logic [11:0] SBD_REG_UPW   = 12'h008;
    localparam logic [11:0] SBD_REG_FSZ   = 12'h00c;
    localparam logic [11:0] SBD_REG_STAT  = 12'h010;

    // Reset values
    localparam logic [31:0] SBD_RST_ZERO = 32'h00000000;

    // Request from the debug-port master
    typedef struct packed {
        logic [35:0] addr;
        logic        write;
        sbd_size_t   size;
        logic [31:0] wdata;
    } sbd_req_t;

    // Answer to the master
    typedef struct packed {
        logic [31:0] rdata;
        logic        err;
    } sbd_rsp_t;

    // Downstream request to one slave
    typedef struct packed {
        logic [2:0]  sel;
        logic [31:0] offs;
        logic        write;
        sbd_size_t   size;
        logic [31:0] wdata;
    } sbd_down_t;

    // Security controls from flash configuration
    typedef struct packed {
        logic        secure;
        logic        sec_bit;
        logic        user_code_protect;
        logic [31:0] upage_w;
        logic [35:0] boot_size;
        logic [35:0] flash_size;
    } sbd_sec_t;

endpackage

// ---- rtl/sbd_top.sv ----
// Operation
// - Clock enable bit written and read back
// - Every transaction carries 36-bit address
// - Byte, halfword and word sizes supported
// - Top nibble selects slave, low 32 offset
// - Code 1 debug unit, code 4 system bus
// - Code 5 aliases the system bus
// - Code 6 service unit, others unallocated
// - Debugger requests synchronised into system clock
// - Access completes only with running system clock
// - Debugger activity restarts clock, stays asleep
// - Bridge reaches memories and flash controller
// - Security measures gate addresses by controls
// - Secure mode hides secure flash code
// - Secure flash and RAM lengths from page word
// - Secure mode user page read only
// - Security bit allows mailbox and page reads
// - User page always readable
// - Protection adds flash controller window access
// - Protection allows flash above boot region
`timescale 1ns/1ps
`default_nettype none
module sbd_top (
    // Clock and reset
    input  wire  logic               i_clk,
    input  wire  logic               i_sys_rst,
    // APB slave
    input  wire  logic               i_psel,
    input  wire  logic               i_penable,
    input  wire  logic               i_pwrite,
    input  wire  logic [11:0]        i_paddr,
    input  wire  logic [31:0]        i_pwdata,
    output logic       [31:0]        o_prdata,
    output logic                     o_pready,
    output logic                     o_pslverr,
    // Service bus request, toggle handshake from debugger domain
    input  wire  logic               i_req_tgl,
    input  wire  sbd_pkg::sbd_req_t  i_req,
    output logic                     o_ack_tgl,
    output sbd_pkg::sbd_rsp_t        o_rsp,
    // Clock state and wake request
    input  wire  logic               i_sysclk_run,
    output logic                     o_clk_wake,
    output logic                     o_port_clock_on,
    // Downstream slaves
    output sbd_pkg::sbd_down_t       o_down,
    output logic                     o_down_vld,
    input  wire  logic               i_down_done,
    input  wire  logic [31:0]        i_down_rdata,
    input  wire  logic               i_down_err
);
    import sbd_pkg::*;

    typedef enum logic [1:0] {
        SBD_IDLE = 2'b00,
        SBD_WAKE = 2'b01,
        SBD_BUSY = 2'b11,
        SBD_DONE = 2'b10
    } sbd_state_t;

    sbd_state_t  state_r;
    sbd_state_t  state_nxt;
    logic [1:0]  tgl_sync_r;
    logic        tgl_seen_r;
    logic        new_req;
    sbd_req_t    req_r;
    sbd_sec_t    sec_r;
    logic        allow;
    logic [2:0]  sel;
    logic        apb_acc;
    logic [31:0] rd_mux;
    logic        err_cnt_up;
    logic [15:0] err_cnt_r;

    function automatic logic [31:0] apb_read(input logic [11:0] ad, input sbd_sec_t s,
                                             input logic ck, input logic [15:0] ec,
                                             input sbd_state_t st);
        case (ad)
            SBD_REG_PCLK:  apb_read = {31'h0, ck};
            SBD_REG_SECCF: apb_read = {29'h0, s.user_code_protect, s.sec_bit, s.secure};
            SBD_REG_UPW:   apb_read = s.upage_w;
            SBD_REG_FSZ:   apb_read = {s.flash_size[19:10], 6'h00, s.boot_size[25:10]};
            SBD_REG_STAT:  apb_read = {14'h0, st, ec};
            default:       apb_read = 32'h00000000;
        endcase
    endfunction

    // Request toggle synchroniser, edge found past the second stage
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tgl_sync_r <= 2'b00;
        end else begin
            tgl_sync_r <= {tgl_sync_r[0], i_req_tgl};
        end
    end
    assign new_req = (tgl_sync_r[1] != tgl_seen_r);

    // Filter and decoder
    sbd_filter u_filter (
        .i_req   (req_r),
        .i_sec   (sec_r),
        .o_allow (allow),
        .o_sel   (sel)
    );

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SBD_IDLE: begin
                if (new_req)
                    state_nxt = SBD_WAKE;
            end
            SBD_WAKE: begin
                if (i_sysclk_run)
                    state_nxt = allow ? SBD_BUSY : SBD_DONE;
            end
            SBD_BUSY: begin
                if (i_down_done)
                    state_nxt = SBD_DONE;
            end
            SBD_DONE: state_nxt = SBD_IDLE;
            default:  state_nxt = SBD_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= SBD_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Capture request; data is stable once the toggle is seen
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            req_r      <= '0;
            tgl_seen_r <= 1'b0;
        end else if (state_r == SBD_IDLE && new_req) begin
            req_r      <= i_req;
            tgl_seen_r <= tgl_sync_r[1];
        end
    end

    // Wake request while a transfer waits on a stopped clock
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_clk_wake <= 1'b0;
        end else begin
            o_clk_wake <= (state_nxt == SBD_WAKE) && !i_sysclk_run;
        end
    end

    // Downstream issue, offset is the low 32 bits
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_down     <= '0;
            o_down_vld <= 1'b0;
        end else begin
            o_down_vld <= (state_nxt == SBD_BUSY);
            if (state_r == SBD_WAKE && i_sysclk_run && allow) begin
                o_down.sel   <= sel;
                o_down.offs  <= req_r.addr[31:0];
                o_down.write <= req_r.write;
                o_down.size  <= req_r.size;
                o_down.wdata <= req_r.wdata;
            end
        end
    end

    // Answer and acknowledge toggle back to the debugger side
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rsp     <= '0;
            o_ack_tgl <= 1'b0;
        end else begin
            if (state_r == SBD_WAKE && i_sysclk_run && !allow) begin
                o_rsp.rdata <= 32'h00000000;
                o_rsp.err   <= 1'b1;
            end else if (state_r == SBD_BUSY && i_down_done) begin
                o_rsp.rdata <= req_r.write ? 32'h00000000 : i_down_rdata;
                o_rsp.err   <= i_down_err;
            end
            if (state_r == SBD_DONE)
                o_ack_tgl <= ~o_ack_tgl;
        end
    end

    // Refused access counter, saturating
    assign err_cnt_up = (state_r == SBD_WAKE) && i_sysclk_run && !allow;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            err_cnt_r <= 16'h0000;
        end else if (err_cnt_up && err_cnt_r != 16'hffff) begin
            err_cnt_r <= err_cnt_r + 16'h0001;
        end
    end

    // APB writes, taken in the access phase
    assign apb_acc = i_psel && i_penable;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_port_clock_on <= 1'b0;
            sec_r           <= '0;
        end else if (apb_acc && i_pwrite) begin
            case (i_paddr)
                SBD_REG_PCLK:  o_port_clock_on <= i_pwdata[0];
                SBD_REG_SECCF: begin
                    sec_r.secure  <= i_pwdata[0];
                    sec_r.sec_bit <= i_pwdata[1];
                    sec_r.user_code_protect   <= i_pwdata[2];
                end
                SBD_REG_UPW:   sec_r.upage_w <= i_pwdata;
                SBD_REG_FSZ: begin
                    sec_r.boot_size  <= {10'h000, i_pwdata[15:0], 10'h000};
                    sec_r.flash_size <= {16'h0000, i_pwdata[31:22], 10'h000};
                end
                default: ;
            endcase
        end
    end

    // APB read data and zero-wait ready
    assign rd_mux = apb_read(i_paddr, sec_r, o_port_clock_on, err_cnt_r, state_r);
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_prdata  <= 32'h00000000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= i_psel && !i_penable;
            o_prdata  <= (i_psel && !i_penable && !i_pwrite) ? rd_mux : 32'h00000000;
            o_pslverr <= i_psel && !i_penable && (i_paddr > SBD_REG_STAT || i_paddr[1:0] != 2'b00);
        end
    end

    // Service path checks

    a_refused_errs: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_r == SBD_WAKE && i_sysclk_run && !allow) |=> o_rsp.err && o_rsp.rdata == 32'h0)
        else $error("refused access did not error");

    a_refused_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_r == SBD_WAKE && !allow) |=> !o_down_vld)
        else $error("refused access reached slave");

    a_wait_clock: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_r == SBD_WAKE && !i_sysclk_run) |=> state_r == SBD_WAKE && o_clk_wake)
        else $error("advanced without system clock");

    a_alias_hsb: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (req_r.addr[35:32] == SBD_SLV_HSB2) |-> sel == 3'b010)
        else $error("alias does not reach system bus");

    a_slave_none: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (req_r.addr[35:32] == SBD_SLV_NONE) |-> !allow)
        else $error("unallocated slave allowed");

    a_offset_pass: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $rose(o_down_vld) |-> o_down.offs == req_r.addr[31:0])
        else $error("offset not passed");

    a_upage_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_r == SBD_WAKE && !req_r.write && req_r.size == SBD_SZ_WORD
         && req_r.addr == SBD_UPAGE_LO) |-> allow)
        else $error("user page read refused");

    a_misalign: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (req_r.size == SBD_SZ_HALF && req_r.addr[0]) |-> !allow)
        else $error("misaligned halfword allowed");

    a_req_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        state_r != SBD_IDLE
        |=> $stable(req_r))
        else $error("request changed in flight");

    a_ack_done: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $changed(o_ack_tgl)
        |-> $past(state_r) == SBD_DONE)
        else $error("stray acknowledge");

    a_down_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_down_vld && !i_down_done
        |=> o_down_vld && $stable(o_down))
        else $error("transfer dropped early");

    a_wake_drop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_sysclk_run
        |=> !o_clk_wake)
        else $error("wake held with clock on");

    a_secure_flash: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        sec_r.secure && req_r.addr >= SBD_FLASH_BASE && req_r.addr < SBD_UPAGE_LO
        && req_r.addr < SBD_FLASH_BASE + {10'h000, sec_r.upage_w[15:0], 10'h000}
        |-> !allow)
        else $error("secure flash exposed");

    a_mbox_open: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        sec_r.sec_bit && req_r.addr == SBD_MBOX_LO && req_r.size == SBD_SZ_WORD
        |-> allow)
        else $error("mailbox refused");

    a_fctl_open: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        sec_r.sec_bit && sec_r.user_code_protect && req_r.addr == SBD_FCTL_LO
        && req_r.size == SBD_SZ_WORD |-> allow)
        else $error("controller window refused");

    a_err_count: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        err_cnt_up && err_cnt_r != 16'hffff
        |=> err_cnt_r == $past(err_cnt_r) + 16'h0001)
        else $error("refusal not counted");

    // Register bus checks
    a_clk_bit: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (apb_acc && i_pwrite && i_paddr == SBD_REG_PCLK) |=> o_port_clock_on == $past(i_pwdata[0]))
        else $error("clock bit not updated");

    a_pready_setup: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_psel && !i_penable
        |=> o_pready)
        else $error("no ready after setup");

    a_pready_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !(i_psel && !i_penable)
        |=> !o_pready)
        else $error("ready outside access");

    a_unmapped_err: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_psel && !i_penable && i_paddr > SBD_REG_STAT
        |=> o_pslverr)
        else $error("unmapped register no error");

    // Scenarios worth seeing
    c_allowed: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        state_r == SBD_BUSY ##[1:20] state_r == SBD_DONE);

    c_refused: cover property (@(posedge i_clk) disable iff (i_sys_rst) err_cnt_up);

    c_wake: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(o_clk_wake));

    c_alias: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        state_r == SBD_BUSY && req_r.addr[35:32] == SBD_SLV_HSB2);

endmodule
`default_nettype wire

// ---- tb/sbd_slave_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Downstream slave stand-in: answers each transfer after a short or long wait
module sbd_slave_model
    import sbd_pkg::*;
(
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_sys_rst,
    // Transfer from the decoder
    input  wire sbd_pkg::sbd_down_t i_down,
    input  wire logic               i_down_vld,
    input  wire logic               i_slow,
    // Answer
    output logic                    o_done,
    output logic [31:0]             o_rdata,
    output logic                    o_err,
    // Bookkeeping for the bench
    output logic [15:0]             o_n_xfer,
    output sbd_pkg::sbd_down_t      o_last
);
    logic [3:0] wait_r;
    logic       busy_r;

    // One answer per transfer, re-armed only once valid drops
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wait_r   <= 4'h0;
            busy_r   <= 1'b0;
            o_done   <= 1'b0;
            o_rdata  <= 32'h00000000;
            o_err    <= 1'b0;
            o_n_xfer <= 16'h0000;
            o_last   <= '0;
        end else begin
            o_done  <= 1'b0;
            // Idle data flips every cycle so stale data never looks valid
            o_rdata <= ~o_rdata;
            if (!busy_r && i_down_vld) begin
                busy_r <= 1'b1;
                wait_r <= i_slow ? 4'h5 : 4'h1;
                o_last <= i_down;
            end else if (busy_r && wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
                if (wait_r == 4'h1) begin
                    o_done   <= 1'b1;
                    o_rdata  <= i_down.offs ^ 32'ha5a5a5a5;
                    o_n_xfer <= o_n_xfer + 16'h0001;
                end
            end else if (busy_r && !i_down_vld) begin
                busy_r <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_sbd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_sbd_top;
    import sbd_pkg::*;
    // Bench signals
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, drdata, rd;
    logic        req_tgl, ack_tgl, run, wake, pclk_on, dvld, ddone, derr, slow, t0, er;
    sbd_req_t    req;
    sbd_rsp_t    rsp;
    sbd_down_t   down, last;
    logic [15:0] n_xfer, n0;
    int          n_errors, n_tests;

    sbd_top sbd_top_i (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_req_tgl(req_tgl), .i_req(req),
        .o_ack_tgl(ack_tgl), .o_rsp(rsp), .i_sysclk_run(run), .o_clk_wake(wake),
        .o_port_clock_on(pclk_on), .o_down(down), .o_down_vld(dvld),
        .i_down_done(ddone), .i_down_rdata(drdata), .i_down_err(derr));
    sbd_slave_model sbd_slave_model_i (.i_clk(clk), .i_sys_rst(rst), .i_down(down),
        .i_down_vld(dvld), .i_slow(slow), .o_done(ddone), .o_rdata(drdata), .o_err(derr),
        .o_n_xfer(n_xfer), .o_last(last));

    // Clock at 125 MHz
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // One APB transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic ok;
        ok = 1'b0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int i = 0; i < 50 && !ok; i++) begin
            @(posedge clk);
            ok = (pready === 1'b1);
        end
        check(ok, 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic xerr);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
        check(er, xerr);
    endtask

    // Service request: operands settle one edge before the toggle
    task automatic svc_go(input logic [35:0] a, input logic w, input logic [1:0] sz);
        n0 = n_xfer;
        t0 = ack_tgl;
        @(posedge clk);
        req <= '{addr: a, write: w, size: sbd_size_t'(sz), wdata: a[31:0] ^ 32'h12345678};
        @(posedge clk);
        req_tgl <= ~req_tgl;
    endtask

    task automatic svc_end(input logic [35:0] a, input logic w, input logic [1:0] sz,
                           input logic xerr, input logic [2:0] xsel);
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < 300 && !ok; i++) begin
            @(negedge clk);
            ok = (ack_tgl !== t0);
        end
        check(ok, 1'b1);
        check(rsp.err, xerr);
        if (!w) check(rsp.rdata, xerr ? 32'h0 : a[31:0] ^ 32'ha5a5a5a5);
        check(n_xfer - n0, {15'h0, !xerr});
        if (!xerr) begin
            check(last.sel, xsel);
            check(last.offs, a[31:0]);
            check({last.write, last.size}, {w, sz});
            check(last.wdata, a[31:0] ^ 32'h12345678);
        end
    endtask

    task automatic svc(input logic [35:0] a, input logic w, input logic [1:0] sz,
                       input logic xerr, input logic [2:0] xsel);
        svc_go(a, w, sz);
        svc_end(a, w, sz, xerr, xsel);
    endtask

    // Watchdog well beyond the expected run
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        final_report();
    end

    initial begin
        logic [3:0] c;
        logic [2:0] s;
        {rst, psel, penable, pwrite, paddr, pwdata, req_tgl, slow} = '0;
        n_errors = 0;
        n_tests  = 0;
        req = '0;
        run = 1'b1;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // Reset values, read-back, unmapped place
        rdc(12'h000, 32'h0, 1'b0);
        rdc(12'h004, 32'h0, 1'b0);
        rdc(12'h020, 32'h0, 1'b1);
        apb(1'b1, 12'h000, 32'h1);
        @(negedge clk);
        check(pclk_on, 1'b1);
        rdc(12'h000, 32'h1, 1'b0);
        apb(1'b1, 12'h000, 32'h0);
        @(negedge clk);
        check(pclk_on, 1'b0);
        rdc(12'h000, 32'h0, 1'b0);
        $display("test registers done");
        // Every slave code, slow slave
        slow = 1'b1;
        for (int k = 0; k < 16; k++) begin
            c = k[3:0];
            s = (c == 4'h1) ? 3'b001 : (c == 4'h4 || c == 4'h5) ? 3'b010 :
                (c == 4'h6) ? 3'b100 : 3'b000;
            svc({c, 32'h80000040}, 1'b0, 2'b10, s == 3'b000, s);
        end
        slow = 1'b0;
        $display("test decode done");
        // Sizes and alignment
        svc(36'h400000001, 1'b0, 2'b00, 1'b0, 3'b010);
        svc(36'h400000001, 1'b0, 2'b01, 1'b1, 3'b010);
        svc(36'h400000002, 1'b1, 2'b01, 1'b0, 3'b010);
        svc(36'h400000002, 1'b1, 2'b10, 1'b1, 3'b010);
        $display("test alignment done");
        // Stopped clock: wake asked, no completion until it runs
        @(posedge clk);
        run <= 1'b0;
        svc_go(36'h100000000, 1'b0, 2'b10);
        for (int i = 0; i < 10 && wake !== 1'b1; i++) @(negedge clk);
        check(wake, 1'b1);
        repeat (20) @(negedge clk);
        check(ack_tgl, t0);
        @(posedge clk);
        run <= 1'b1;
        svc_end(36'h100000000, 1'b0, 2'b10, 1'b0, 3'b001);
        $display("test sleep done");
        // Secure mode: flash 4 KiB, RAM 2 KiB hidden, page read only
        apb(1'b1, 12'h008, 32'h00020004);
        apb(1'b1, 12'h004, 32'h1);
        rdc(12'h004, 32'h1, 1'b0);
        svc(36'h580000ffc, 1'b0, 2'b10, 1'b1, 3'b010);
        svc(36'h580001000, 1'b0, 2'b10, 1'b0, 3'b010);
        svc(36'h5000007fc, 1'b1, 2'b10, 1'b1, 3'b010);
        svc(36'h500000800, 1'b0, 2'b10, 1'b0, 3'b010);
        svc(36'h580800000, 1'b0, 2'b10, 1'b0, 3'b010);
        svc(36'h580800000, 1'b1, 2'b10, 1'b1, 3'b010);
        svc(36'h100000000, 1'b0, 2'b10, 1'b0, 3'b001);
        $display("test secure done");
        // Security bit alone
        apb(1'b1, 12'h004, 32'h2);
        svc(36'h100000114, 1'b1, 2'b10, 1'b0, 3'b001);
        svc(36'h100000110, 1'b0, 2'b10, 1'b0, 3'b001);
        svc(36'h10000010c, 1'b0, 2'b10, 1'b1, 3'b001);
        svc(36'h580fffffc, 1'b0, 2'b10, 1'b0, 3'b010);
        svc(36'h580800000, 1'b1, 2'b10, 1'b1, 3'b010);
        svc(36'h581000000, 1'b0, 2'b10, 1'b1, 3'b010);
        svc(36'h600000000, 1'b0, 2'b10, 1'b1, 3'b100);
        $display("test security bit done");
        // User code protection: boot 4 KiB, flash 64 KiB
        apb(1'b1, 12'h00c, 32'h10000004);
        apb(1'b1, 12'h004, 32'h6);
        rdc(12'h00c, 32'h10000004, 1'b0);
        svc(36'h580000ffc, 1'b0, 2'b10, 1'b1, 3'b010);
        svc(36'h580001000, 1'b1, 2'b10, 1'b0, 3'b010);
        svc(36'h58000fffc, 1'b0, 2'b10, 1'b0, 3'b010);
        svc(36'h580010000, 1'b0, 2'b10, 1'b1, 3'b010);
        svc(36'h5fffe0000, 1'b1, 2'b10, 1'b0, 3'b010);
        svc(36'h5fffe03fc, 1'b0, 2'b10, 1'b0, 3'b010);
        svc(36'h5fffe0400, 1'b0, 2'b10, 1'b1, 3'b010);
        svc(36'h100000200, 1'b0, 2'b10, 1'b1, 3'b001);
        svc(36'h100000110, 1'b0, 2'b10, 1'b0, 3'b001);
        $display("test user protect done");
        rdc(12'h010, 32'h00000019, 1'b0);
        rst     <= 1'b1;
        req_tgl <= 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(12'h004, 32'h0, 1'b0);
        rdc(12'h010, 32'h0, 1'b0);
        $display("test count and reset done");
        final_report();
    end
endmodule
`default_nettype wire
